// *** rtl/pull_in_limit_pkg.sv ***
// Purpose: shared constants for the loop pull-in limit register bank
// Assumes: byte-wide register port, one clock
// Notes: offsets are register addresses on the serial configuration port
package pull_in_limit_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int LIMIT_W = 10;
	localparam int FREQ_W = 24;
	localparam logic [6:0] LIMIT_LOW_ADDR = 7'h41;
	localparam logic [6:0] LIMIT_HIGH_ADDR = 7'h42;
	localparam logic [7:0] LIMIT_LOW_RESET = 8'h76;
	localparam logic [1:0] LIMIT_HIGH_RESET = 2'h0;
	localparam int HIGH_FIELD_MSB = 1;
	localparam int HIGH_FIELD_LSB = 0;
	// limit step in units of 0.001 ppm-style fixed point: 0.07 -> 70 steps of 1/1000
	localparam int SCALE_NUM = 70;
endpackage

// *** rtl/loop_offset_clamp.sv ***
// Purpose: clamp one timing loop's frequency offset to +/- limit
// Assumes: offsets already relative to the calibrated oscillator
// Notes: registered output, one cycle latency
`timescale 1ns/100ps
`default_nettype none
module loop_offset_clamp
#(
	parameter int W = 24
)
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic signed [W-1:0] i_request,
	input wire logic [W-1:0] i_bound,
	output logic signed [W-1:0] o_offset,
	output logic o_limited
);
	logic signed [W:0] req_x;
	logic signed [W:0] pos_x;
	logic signed [W:0] neg_x;
	assign req_x = {i_request[W-1], i_request};
	assign pos_x = {1'b0, i_bound};
	assign neg_x = -pos_x;
	// saturate at the boundary, pass through inside the range
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			o_offset <= '0;
			o_limited <= 1'b0;
		end
		else if (i_ce)
		begin
			if (req_x > pos_x)
			begin
				o_offset <= pos_x[W-1:0];
				o_limited <= 1'b1;
			end
			else if (req_x < neg_x)
			begin
				o_offset <= neg_x[W-1:0];
				o_limited <= 1'b1;
			end
			else
			begin
				o_offset <= i_request;
				o_limited <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/pull_in_limit_regs.sv ***
// Purpose: pull-in limit registers and clamping of both timing loops
// Assumes: simple byte register port from the serial interface
// Notes: offsets in scaled units relative to calibrated oscillator
// What this block does
// - limit sets both loops' pull-in range
// - offset measured against the calibrated oscillator (i_osc_cal_offset subtracted)
// - calibrated oscillator used automatically as reference
// - limit is high[1:0] joined with low[7:0]
// - high register holds only bits 9:8
// - unsigned limit bounds both offset directions
// - offset bound is limit times 0.07 scale
`timescale 1ns/100ps
`default_nettype none
module pull_in_limit_regs
	import pull_in_limit_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_wr_en,
	input wire logic [pull_in_limit_pkg::ADDR_W-1:0] i_addr,
	input wire logic [pull_in_limit_pkg::DATA_W-1:0] i_wr_data,
	output logic [pull_in_limit_pkg::DATA_W-1:0] o_rd_data,
	input wire logic signed [pull_in_limit_pkg::FREQ_W-1:0] i_main_loop_freq,
	input wire logic signed [pull_in_limit_pkg::FREQ_W-1:0] i_aux_loop_freq,
	input wire logic signed [pull_in_limit_pkg::FREQ_W-1:0] i_osc_cal_offset,
	output logic signed [pull_in_limit_pkg::FREQ_W-1:0] o_main_loop_offset,
	output logic signed [pull_in_limit_pkg::FREQ_W-1:0] o_aux_loop_offset,
	output logic o_main_limited,
	output logic o_aux_limited,
	output logic [pull_in_limit_pkg::LIMIT_W-1:0] o_pull_in_limit_value
);
	logic [7:0] limit_low_q;
	logic [1:0] limit_high_q;
	logic [LIMIT_W-1:0] limit_value;
	logic [FREQ_W-1:0] bound;
	logic signed [FREQ_W-1:0] main_req;
	logic signed [FREQ_W-1:0] aux_req;

	// register writes
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			limit_low_q <= LIMIT_LOW_RESET;
			limit_high_q <= LIMIT_HIGH_RESET;
		end
		else if (i_ce && i_wr_en)
		begin
			if (i_addr == LIMIT_LOW_ADDR)
				limit_low_q <= i_wr_data;
			if (i_addr == LIMIT_HIGH_ADDR)
				limit_high_q <= i_wr_data[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
		end
	end

	// readback, unused bits and unmapped addresses read zero
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			o_rd_data <= '0;
		else if (i_ce)
		begin
			case (i_addr)
				LIMIT_LOW_ADDR: o_rd_data <= limit_low_q;
				LIMIT_HIGH_ADDR: o_rd_data <= {6'h00, limit_high_q};
				default: o_rd_data <= '0;
			endcase
		end
	end

	// limit assembly and scaling
	assign limit_value = {limit_high_q, limit_low_q};
	assign o_pull_in_limit_value = limit_value;
	assign bound = FREQ_W'(limit_value) * FREQ_W'(SCALE_NUM);

	// offsets relative to the calibrated oscillator
	assign main_req = i_main_loop_freq - i_osc_cal_offset;
	assign aux_req = i_aux_loop_freq - i_osc_cal_offset;

	// same bound for both loops
	loop_offset_clamp #(.W(FREQ_W)) u_main_clamp (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_request(main_req),
		.i_bound(bound),
		.o_offset(o_main_loop_offset),
		.o_limited(o_main_limited)
	);
	loop_offset_clamp #(.W(FREQ_W)) u_aux_clamp (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_request(aux_req),
		.i_bound(bound),
		.o_offset(o_aux_loop_offset),
		.o_limited(o_aux_limited)
	);
endmodule
`default_nettype wire

// *** test/pull_in_limit_assertions.sv ***
// Purpose: port checks for the limit bank
// Assumes: one clock, sync reset
// Notes: bound is 70 times limit
`timescale 1ns/100ps
`default_nettype none
module pull_in_limit_chk (
	input wire logic i_sys_clk, i_sys_rst, i_ce, i_wr_en, o_main_limited,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wr_data, o_rd_data,
	input wire logic [9:0] o_pull_in_limit_value,
	input wire logic signed [23:0] i_main_loop_freq, i_osc_cal_offset, o_main_loop_offset
);
	int b, m;
	wire [9:0] l = o_pull_in_limit_value;
	wire signed [23:0] o = o_main_loop_offset;
	wire w = i_ce && !i_wr_en;
	wire v = i_ce && i_wr_en;
	// bound, calibrated request, out of range
	assign b = 70 * l;
	assign m = i_main_loop_freq - i_osc_cal_offset;
	wire f = m > b || m < -b;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	a_low_wr: assert property (v && i_addr == 7'h41 |=> l[7:0] == $past(i_wr_data))
		else $error("low write");
	a_high_wr: assert property (v && i_addr == 7'h42 |=> l[9:8] == $past(i_wr_data[1:0]))
		else $error("high write");
	a_low_rd: assert property (w && i_addr == 7'h41 |=> o_rd_data == l[7:0])
		else $error("low read");
	a_high_rd: assert property (w && i_addr == 7'h42 |=> o_rd_data == l[9:8])
		else $error("high read");
	a_track_in: assert property (w && !f |=> o == $past(m)) else $error("track");
	a_clamp_hi: assert property (w && m > b |=> o == b) else $error("clamp hi");
	a_clamp_lo: assert property (w && m < -b |=> o == -b) else $error("clamp lo");
	a_main_lim: assert property (w |=> o_main_limited == $past(f)) else $error("flag");
endmodule
bind pull_in_limit_regs pull_in_limit_chk chk (.*);
`default_nettype wire

// *** test/pull_in_limit_regs_bench.sv ***
// Purpose: bench for the limit bank
// Assumes: clock enable held high except for one cycle in the enable test
// Notes: main loop judged by checker
`timescale 1ns/100ps
`default_nettype none
`define CK(g,e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %0t value %h", $time, g); end end
module pull_in_limit_regs_bench;
	logic i_sys_clk = 0, i_sys_rst = 1, i_ce = 1, i_wr_en = 0, o_main_limited, o_aux_limited;
	logic [6:0] i_addr = 0;
	logic [7:0] i_wr_data = 0, o_rd_data;
	logic [9:0] o_pull_in_limit_value;
	logic signed [23:0] i_main_loop_freq = 0, i_aux_loop_freq = 0, i_osc_cal_offset = 0;
	logic signed [23:0] o_main_loop_offset, o_aux_loop_offset;
	int err_count = 0, checked = 0;
	wire c = i_sys_clk;
	pull_in_limit_regs DUT (.*);
	// clock
	initial forever #5 i_sys_clk = ~i_sys_clk;
	// watchdog
	initial begin #5us; err_count++; print_verdict; end
	// register access, then readback
	task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d, e);
		@(posedge c) {i_wr_en, i_addr, i_wr_data} <= {w, a, d};
		@(posedge c) i_wr_en <= 0;
		@(posedge c) #1 `CK(o_rd_data, e)
	endtask
	// one loop step, aux result
	task automatic lp(input logic signed [23:0] m, x, e, input logic f);
		@(posedge c) {i_main_loop_freq, i_aux_loop_freq} <= {m, x};
		@(posedge c) #1 `CK({o_aux_loop_offset, o_aux_limited}, {e, f})
	endtask
	task automatic print_verdict;
		$display("%0d checked, %0d mismatches", checked, err_count);
		if (err_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// tests
	initial begin
		repeat (16) @(posedge c);
		{i_sys_rst, i_osc_cal_offset} <= {1'b0, 24'sd100};
		op(0, 7'h41, 0, 8'h76);
		op(1, 7'h42, 8'hff, 8'h03);
		op(0, 7'h40, 0, 0);
		$display("register test done");
		op(1, 7'h41, 8'h10, 8'h10);
		op(1, 7'h42, 0, 0);
		`CK(o_pull_in_limit_value, 10'h010)
		// a write while the clock enable is low must leave the register alone
		@(posedge c) {i_ce, i_wr_en, i_addr, i_wr_data} <= {1'b0, 1'b1, 7'h41, 8'h55};
		@(posedge c) {i_ce, i_wr_en} <= {1'b1, 1'b0};
		op(0, 7'h41, 0, 8'h10);
		$display("enable test done");
		lp(-2000, 2000, 1120, 1);
		lp(1220, 0, -100, 0);
		lp(1221, -1021, -1120, 1);
		$display("clamp test done");
		print_verdict;
	end
endmodule
`default_nettype wire
